// [logic/irct_carrier.sv]
// carrier generator: 7-bit counter with high and low period modulo values
`timescale 1ns/1ps

module irct_carrier #(
    parameter int CW = 7
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic          run,
    input  wire logic [CW-1:0] high_period,
    input  wire logic [CW-1:0] low_period,
    output logic               carrier
);

    logic [CW-1:0] cnt_q;

    // ------------------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------------------
    // each phase lasts period+1 ticks; stopped generator parks low
    always_ff @(posedge mclk)
    begin
        if (rst || !run)
        begin
            cnt_q   <= '0;
            carrier <= 1'b0;
        end
        else if (tick)
        begin
            if (cnt_q == (carrier ? high_period : low_period))
            begin
                cnt_q   <= '0;
                carrier <= ~carrier;
            end
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end

    property p_phase_len;
        @(posedge mclk) disable iff (rst || !run)
            (tick && cnt_q == (carrier ? high_period : low_period)) |=> $changed(carrier);
    endproperty
    a_phase_len: assert property (p_phase_len) else $error("carrier phase ended late");

endmodule

// [logic/irct_defines.svh]
// constants for the ir carrier timer: offsets, fields, reset values, dividers
`ifndef IRCT_DEFINES_SVH
`define IRCT_DEFINES_SVH

// ----------------------------------------------------------------------------
// register file addresses
// ----------------------------------------------------------------------------
`define IRCT_RF_T8_CTRL     7'h33
`define IRCT_RF_T8_SYNC     7'h14
`define IRCT_RF_T8_IRQ      7'h3D
`define IRCT_RF_TX_GATE     7'h3E
`define IRCT_RF_T8_FILT     7'h13

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define IRCT_CTRL_EN_BIT    3
`define IRCT_CTRL_CLR_BIT   2
`define IRCT_CTRL_CKH_BIT   1
`define IRCT_CTRL_CKL_BIT   0
`define IRCT_SYNC_EXT_BIT   0
`define IRCT_SYNC_PAIR_BIT  3
`define IRCT_SYNC_T10_BIT   2
`define IRCT_IRQ_BIT        0
`define IRCT_GATE_BIT       0
`define IRCT_GATEBUF_BIT    1
`define IRCT_FILT_BIT       3
`define IRCT_LOW_SEL_BIT    7

// ----------------------------------------------------------------------------
// peripheral (data buffer) addresses
// ----------------------------------------------------------------------------
`define IRCT_PA_T8          4'h1
`define IRCT_PA_CAR_HI      4'h2
`define IRCT_PA_CAR_LO      4'h3

// ----------------------------------------------------------------------------
// reset values and dividers
// ----------------------------------------------------------------------------
`define IRCT_CTRL_RESET     4'h8
`define IRCT_DIV_32         8'h1F
`define IRCT_DIV_64         8'h3F
`define IRCT_DIV_256        8'hFF

`endif

// [logic/irct_pkg.sv]
// types shared by the ir carrier timer files
package irct_pkg;

    typedef enum logic [1:0]
    {
        IRCT_CK_DIV32  = 2'b00,
        IRCT_CK_DIV64  = 2'b01,
        IRCT_CK_DIV256 = 2'b10,
        IRCT_CK_ALT    = 2'b11
    } irct_clksel_t;

    // register file access
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [3:0] wdata;
    } irct_rf_req_t;

    // data buffer get/put access
    typedef struct packed
    {
        logic       put;
        logic       get;
        logic [3:0] addr;
        logic [7:0] wdata;
    } irct_dbf_req_t;

endpackage

// [logic/irct_timer8.sv]
// 8-bit modulo timer with carrier generator, ir output and paired-timer sync
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "irct_defines.svh"

module irct_timer8 #(
    parameter int PSW = 8
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire irct_pkg::irct_rf_req_t  rf_req,
    output logic [3:0]                 rf_rdata,
    input  wire irct_pkg::irct_dbf_req_t dbf_req,
    output logic [7:0]                 data_buffer_port,
    input  wire logic                  stop_release,
    input  wire logic                  t8_ext_input_pin,
    input  wire logic                  comparator_out,
    input  wire logic                  envelope_in,
    output logic                       t10_run,
    output logic                       t10_count_tick,
    output logic                       t8_toggle_pin,
    output logic                       ir_tx_pin,
    output logic                       tx_indicator_pin,
    output logic                       t8_match_irq_flag
);

    logic [7:0]  t8_count_value;
    logic [7:0]  t8_match_limit;
    logic        t8_count_enable;
    logic [1:0]  t8_clksel;
    logic        t8_external_clock_select;
    logic        t8_noise_filter_enable;
    logic        paired_timer_sync;
    logic        t10_count_enable;
    logic        tx_gate;
    logic        tx_gate_buffer;
    logic [7:0]  carrier_high_period;
    logic [7:0]  carrier_low_period;
    logic [PSW-1:0] pre_q;
    logic        half_q;
    logic        carrier;
    logic        alt_q;
    logic        alt_prev_q;
    logic        t8_tick;
    logic        match;
    logic        rf_wr_ctrl;
    logic        rf_wr_sync;
    logic        clear_strobe;
    logic        rem_follow_q;

    assign rf_wr_ctrl   = rf_req.wr && rf_req.addr == `IRCT_RF_T8_CTRL;
    assign rf_wr_sync   = rf_req.wr && rf_req.addr == `IRCT_RF_T8_SYNC;
    assign clear_strobe = rf_wr_ctrl && rf_req.wdata[`IRCT_CTRL_CLR_BIT];

    // ------------------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            half_q <= 1'b0;
        else
            half_q <= ~half_q;
    end

    // alternate source is sampled as a level; a rising edge is one tick
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            alt_q      <= 1'b0;
            alt_prev_q <= 1'b0;
        end
        else
        begin
            alt_q      <= t8_external_clock_select
                          ? (t8_ext_input_pin | comparator_out) : carrier;
            alt_prev_q <= alt_q;
        end
    end

    always_comb
    begin
        unique case (irct_pkg::irct_clksel_t'(t8_clksel))
            irct_pkg::IRCT_CK_DIV32:  t8_tick = pre_q[4:0] == 5'(`IRCT_DIV_32);
            irct_pkg::IRCT_CK_DIV64:  t8_tick = pre_q[5:0] == 6'(`IRCT_DIV_64);
            irct_pkg::IRCT_CK_DIV256: t8_tick = pre_q[7:0] == `IRCT_DIV_256;
            irct_pkg::IRCT_CK_ALT:    t8_tick = alt_q && !alt_prev_q;
        endcase
    end

    // a zero limit never matches, so the flag is never raised
    assign match = t8_count_enable && t8_tick && t8_match_limit != 8'h00
                   && t8_count_value + 8'h01 == t8_match_limit;

    // ------------------------------------------------------------------------
    // register file controls
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            t8_clksel <= 2'b00;
        else if (rf_wr_ctrl)
            t8_clksel <= rf_req.wdata[`IRCT_CTRL_CKH_BIT:`IRCT_CTRL_CKL_BIT];
    end

    // enable pair: stop release wins over a sync-mode stop, which wins over a sync start
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            t8_count_enable  <= 1'(`IRCT_CTRL_RESET >> `IRCT_CTRL_EN_BIT);
            t10_count_enable <= 1'b0;
        end
        else if (stop_release)
            t8_count_enable <= 1'b1;
        else if (paired_timer_sync && match)
        begin
            t8_count_enable  <= 1'b0;
            t10_count_enable <= 1'b0;
        end
        else if (rf_wr_ctrl || rf_wr_sync)
        begin
            if (rf_wr_ctrl)
                t8_count_enable <= rf_req.wdata[`IRCT_CTRL_EN_BIT];
            if (rf_wr_sync)
                t10_count_enable <= rf_req.wdata[`IRCT_SYNC_T10_BIT];
            if (paired_timer_sync
                && ((rf_wr_ctrl && rf_req.wdata[`IRCT_CTRL_EN_BIT])
                    || (rf_wr_sync && rf_req.wdata[`IRCT_SYNC_T10_BIT])))
            begin
                t8_count_enable  <= 1'b1;
                t10_count_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            t8_external_clock_select <= 1'b0;
            paired_timer_sync        <= 1'b0;
        end
        else if (rf_wr_sync)
        begin
            t8_external_clock_select <= rf_req.wdata[`IRCT_SYNC_EXT_BIT];
            paired_timer_sync        <= rf_req.wdata[`IRCT_SYNC_PAIR_BIT];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            t8_noise_filter_enable <= 1'b0;
        else if (rf_req.wr && rf_req.addr == `IRCT_RF_T8_FILT)
            t8_noise_filter_enable <= rf_req.wdata[`IRCT_FILT_BIT];
    end

    // ------------------------------------------------------------------------
    // counter, limit, flag and toggle pin
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst || clear_strobe)
            t8_count_value <= 8'h00;
        else if (match && !paired_timer_sync)
            t8_count_value <= 8'h00;
        else if (match)
            t8_count_value <= t8_match_limit;
        else if (t8_count_enable && t8_tick)
            t8_count_value <= t8_count_value + 8'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            t8_match_limit <= 8'h00;
        else if (dbf_req.put && dbf_req.addr == `IRCT_PA_T8)
            t8_match_limit <= dbf_req.wdata;
    end

    // a match in the clearing cycle still sets the flag
    always_ff @(posedge mclk)
    begin
        if (rst)
            t8_match_irq_flag <= 1'b0;
        else if (match)
            t8_match_irq_flag <= 1'b1;
        else if (clear_strobe)
            t8_match_irq_flag <= 1'b0;
        else if (rf_req.wr && rf_req.addr == `IRCT_RF_T8_IRQ
                 && !rf_req.wdata[`IRCT_IRQ_BIT])
            t8_match_irq_flag <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || clear_strobe)
            t8_toggle_pin <= 1'b1;
        else if (match)
            t8_toggle_pin <= ~t8_toggle_pin;
    end

    // ------------------------------------------------------------------------
    // paired 10-bit timer control
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst || !t10_count_enable || !paired_timer_sync)
            t10_run <= 1'b0;
        else if (t8_tick)
            t10_run <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            t10_count_tick <= 1'b0;
        else
            t10_count_tick <= t10_run && t10_count_enable && envelope_in
                              && paired_timer_sync;
    end

    // ------------------------------------------------------------------------
    // carrier generator and ir output
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            carrier_high_period <= 8'h00;
            carrier_low_period  <= 8'h00;
        end
        else if (dbf_req.put && dbf_req.addr == `IRCT_PA_CAR_HI)
            carrier_high_period <= {1'b0, dbf_req.wdata[6:0]};
        else if (dbf_req.put && dbf_req.addr == `IRCT_PA_CAR_LO)
            carrier_low_period <= dbf_req.wdata;
    end

    // the generator keeps running while it clocks the timer even with gate low
    irct_carrier #(
        .CW (7)
    ) u_carrier (
        .mclk        (mclk),
        .rst         (rst),
        .tick        (half_q),
        .run         (tx_gate || rem_follow_q
                      || (t8_clksel == 2'b11 && !t8_external_clock_select)),
        .high_period (carrier_high_period[6:0]),
        .low_period  (carrier_low_period[6:0]),
        .carrier     (carrier)
    );

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_gate        <= 1'b0;
            tx_gate_buffer <= 1'b0;
        end
        else
        begin
            if (rf_req.wr && rf_req.addr == `IRCT_RF_TX_GATE)
            begin
                tx_gate        <= rf_req.wdata[`IRCT_GATE_BIT];
                tx_gate_buffer <= rf_req.wdata[`IRCT_GATEBUF_BIT];
            end
            if (match)
                tx_gate <= tx_gate_buffer;
        end
    end

    // hold the high pulse until the carrier itself falls
    always_ff @(posedge mclk)
    begin
        if (rst)
            rem_follow_q <= 1'b0;
        else if (tx_gate)
            rem_follow_q <= 1'b1;
        else if (!carrier || carrier_low_period[`IRCT_LOW_SEL_BIT])
            rem_follow_q <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ir_tx_pin        <= 1'b0;
            tx_indicator_pin <= 1'b1;
        end
        else
        begin
            ir_tx_pin <= (tx_gate || (rem_follow_q && carrier))
                         && (carrier_low_period[`IRCT_LOW_SEL_BIT] || carrier);
            tx_indicator_pin <= ~tx_gate;
        end
    end

    // ------------------------------------------------------------------------
    // read paths
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            rf_rdata <= 4'h0;
        else if (rf_req.rd)
        begin
            unique case (rf_req.addr)
                `IRCT_RF_T8_CTRL: rf_rdata <= {t8_count_enable, 1'b0, t8_clksel};
                `IRCT_RF_T8_SYNC: rf_rdata <= {paired_timer_sync, t10_count_enable,
                                               1'b0, t8_external_clock_select};
                `IRCT_RF_T8_IRQ:  rf_rdata <= {3'b000, t8_match_irq_flag};
                `IRCT_RF_TX_GATE: rf_rdata <= {2'b00, tx_gate_buffer, tx_gate};
                `IRCT_RF_T8_FILT: rf_rdata <= {t8_noise_filter_enable, 3'b000};
                default:          rf_rdata <= 4'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            data_buffer_port <= 8'h00;
        else if (dbf_req.get)
        begin
            unique case (dbf_req.addr)
                `IRCT_PA_T8:     data_buffer_port <= t8_count_value;
                `IRCT_PA_CAR_HI: data_buffer_port <= carrier_high_period;
                `IRCT_PA_CAR_LO: data_buffer_port <= carrier_low_period;
                default:         data_buffer_port <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_match_irq;
        @(posedge mclk) disable iff (rst) match |=> t8_match_irq_flag;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match lost irq");

    property p_match_toggle;
        @(posedge mclk) disable iff (rst) (match && !clear_strobe) |=> $changed(t8_toggle_pin);
    endproperty
    a_match_toggle: assert property (p_match_toggle) else $error("pin not toggled");

    property p_clear;
        @(posedge mclk) disable iff (rst)
            clear_strobe |=> (t8_count_value == 8'h00 && t8_toggle_pin);
    endproperty
    a_clear: assert property (p_clear) else $error("clear strobe ignored");

    property p_hold_disabled;
        @(posedge mclk) disable iff (rst)
            (!t8_count_enable && !clear_strobe) |=> $stable(t8_count_value);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("count moved");

    property p_stop_release;
        @(posedge mclk) disable iff (rst) stop_release |=> t8_count_enable;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("enable not set");

    property p_sync_stop;
        @(posedge mclk) disable iff (rst)
            (paired_timer_sync && match && !stop_release)
            |=> (!t8_count_enable && !t10_count_enable) ##1 !t10_count_tick;
    endproperty
    a_sync_stop: assert property (p_sync_stop) else $error("sync stop failed");

    property p_wrap;
        @(posedge mclk) disable iff (rst)
            (match && !paired_timer_sync && !clear_strobe) |=> t8_count_value == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap on match");

    property p_gate_copy;
        @(posedge mclk) disable iff (rst)
            match |=> tx_gate == $past(tx_gate_buffer) ##1 tx_indicator_pin == ~$past(tx_gate);
    endproperty
    a_gate_copy: assert property (p_gate_copy) else $error("gate not copied");

    property p_envelope;
        @(posedge mclk) disable iff (rst) !envelope_in |=> !t10_count_tick;
    endproperty
    a_envelope: assert property (p_envelope) else $error("t10 ticked w/o envelope");

endmodule

// [test/irct_ir_front.sv]
// far-side model: remote receive front end feeding the timer input and envelope
`timescale 1ns/1ps

module irct_ir_front (
    input  wire logic mclk,
    input  wire logic ext_run,
    input  wire logic cmp_run,
    input  wire logic env_hi,
    output logic      t8_ext_input_pin,
    output logic      comparator_out,
    output logic      envelope_in
);
    logic [2:0] div_q = 3'h0;

    // ----------------------------------------------------------------------------
    // received carrier
    // ----------------------------------------------------------------------------
    // one period per 8 mclk while a burst runs; each line stays low between bursts
    always @(negedge mclk)
    begin
        div_q            <= (ext_run | cmp_run) ? div_q + 3'h1 : 3'h0;
        t8_ext_input_pin <= ext_run & div_q[2];
        comparator_out   <= cmp_run & div_q[2];
    end
    assign envelope_in    = env_hi;
endmodule

// [test/irct_timer8_tb.sv]
// self-checking bench for the ir carrier timer
`timescale 1ns/1ps
`include "irct_defines.svh"

module irct_timer8_tb;
    logic                    mclk = 1'b0;
    logic                    rst = 1'b1;
    irct_pkg::irct_rf_req_t  rf_req = '0;
    irct_pkg::irct_dbf_req_t dbf_req = '0;
    logic                    stop_release = 1'b0;
    logic                    ext_run = 1'b0;
    logic                    cmp_run = 1'b0;
    logic                    env_hi = 1'b0;
    logic                    t8_ext_input_pin;
    logic                    comparator_out;
    logic                    envelope_in;
    logic [3:0]              rf_rdata;
    logic [7:0]              data_buffer_port;
    logic                    t10_run;
    logic                    t10_count_tick;
    logic                    t8_toggle_pin;
    logic                    ir_tx_pin;
    logic                    tx_indicator_pin;
    logic                    t8_match_irq_flag;
    logic [7:0]              rd8;
    logic [7:0]              rd8b;
    int                      miscompares = 0;
    int                      num_checks = 0;
    int                      cycles = 0;

    always #2 mclk = ~mclk;

    irct_timer8 #(.PSW(8)) u_irct_timer8 (
        .mclk(mclk), .rst(rst), .rf_req(rf_req), .rf_rdata(rf_rdata), .dbf_req(dbf_req),
        .data_buffer_port(data_buffer_port), .stop_release(stop_release),
        .t8_ext_input_pin(t8_ext_input_pin), .comparator_out(comparator_out),
        .envelope_in(envelope_in), .t10_run(t10_run), .t10_count_tick(t10_count_tick),
        .t8_toggle_pin(t8_toggle_pin), .ir_tx_pin(ir_tx_pin),
        .tx_indicator_pin(tx_indicator_pin), .t8_match_irq_flag(t8_match_irq_flag));

    irct_ir_front u_irct_ir_front (
        .mclk(mclk), .ext_run(ext_run), .cmp_run(cmp_run), .env_hi(env_hi),
        .t8_ext_input_pin(t8_ext_input_pin), .comparator_out(comparator_out),
        .envelope_in(envelope_in));

    // ----------------------------------------------------------------------------
    // bus, wait and check tasks
    // ----------------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run needs about 3000 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic rf_acc(input logic w, input logic [6:0] a, input logic [3:0] d);
        @(negedge mclk);
        rf_req = '{w, ~w, a, d};
        @(negedge mclk);
        rf_req = '0;
        rd8 = {4'h0, rf_rdata};
    endtask

    task automatic db_acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        dbf_req = '{w, ~w, a, d};
        @(negedge mclk);
        dbf_req = '0;
        rd8 = data_buffer_port;
    endtask

    // cycles until the signal leaves its present level, bounded
    task automatic wait_chg(ref logic s, output int t);
        logic v;
        v = s;
        t = 0;
        while (s === v && t < 2000)
        begin
            @(negedge mclk);
            t++;
        end
    endtask

    // ----------------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------------
    task automatic t_reset();
        rf_acc(1'b0, `IRCT_RF_T8_CTRL, 4'h0);
        chk(rd8, 16'h0008, "ctrl after reset");
        chk({t8_toggle_pin, ir_tx_pin, tx_indicator_pin, t8_match_irq_flag}, 16'h000A,
            "pins after reset");
    endtask

    task automatic t_clksel();
        int t;
        int div[3] = '{32, 64, 256};
        db_acc(1'b1, `IRCT_PA_T8, 8'h02); // nonzero limit only
        for (int k = 0; k < 3; k++)
        begin
            rf_acc(1'b1, `IRCT_RF_T8_CTRL, {2'b11, 2'(k)});
            wait_chg(t8_toggle_pin, t);
            wait_chg(t8_toggle_pin, t);
            chk(16'(t), 16'(2 * div[k]), "match period");
            chk(t8_match_irq_flag, 16'h0001, "flag on match");
            repeat (20) @(negedge mclk);
            chk(t8_match_irq_flag, 16'h0001, "flag sticky");
        end
        rf_acc(1'b1, `IRCT_RF_T8_IRQ, 4'h0);
        chk(t8_match_irq_flag, 16'h0000, "flag cleared by write");
        wait_chg(t8_toggle_pin, t);
    endtask

    task automatic t_hold();
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'h0);
        db_acc(1'b0, `IRCT_PA_T8, 8'h00);
        rd8b = rd8;
        repeat (600) @(negedge mclk);
        db_acc(1'b0, `IRCT_PA_T8, 8'h00);
        chk(rd8, rd8b, "count held while disabled");
        chk(t8_toggle_pin, 16'h0000, "toggle low before clear");
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'h4);
        db_acc(1'b0, `IRCT_PA_T8, 8'h00);
        chk(rd8, 16'h0000, "count after clear");
        chk({t8_toggle_pin, t8_match_irq_flag}, 16'h0002, "pin and flag after clear");
        rf_acc(1'b0, `IRCT_RF_T8_CTRL, 4'h0);
        chk(rd8, 16'h0000, "clear bit reads zero");
        @(negedge mclk);
        stop_release = 1'b1;
        @(negedge mclk);
        stop_release = 1'b0;
        rf_acc(1'b0, `IRCT_RF_T8_CTRL, 4'h0);
        chk(rd8, 16'h0008, "enable forced on stop release");
    endtask

    task automatic t_carrier();
        int t;
        int n;
        logic lvl;
        db_acc(1'b1, `IRCT_PA_CAR_HI, 8'h02);
        db_acc(1'b1, `IRCT_PA_CAR_LO, 8'h03);
        db_acc(1'b0, `IRCT_PA_CAR_HI, 8'h00);
        chk(rd8, 16'h0002, "high period readback");
        db_acc(1'b0, `IRCT_PA_CAR_LO, 8'h00);
        chk(rd8, 16'h0003, "low period readback");
        // clear first: the next match is then at least one full tick away
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'hC);
        rf_acc(1'b1, `IRCT_RF_TX_GATE, 4'h2);
        chk(ir_tx_pin, 16'h0000, "ir low with gate clear");
        wait_chg(tx_indicator_pin, t);
        chk(16'(t <= 70), 16'h0001, "gate loaded at match");
        wait_chg(ir_tx_pin, t);
        repeat (2)
        begin
            lvl = ir_tx_pin;
            wait_chg(ir_tx_pin, t);
            chk(16'(t), lvl ? 16'h0006 : 16'h0008, "carrier phase");
        end
        db_acc(1'b1, `IRCT_PA_CAR_LO, 8'h83);
        repeat (20) @(negedge mclk);
        n = 0;
        repeat (16) @(negedge mclk) n += ir_tx_pin;
        chk(16'(n), 16'h0010, "steady high select");
        db_acc(1'b1, `IRCT_PA_CAR_LO, 8'h03);
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'h0); // no match may move the gate from here
        while (ir_tx_pin !== 1'b0) @(negedge mclk);
        wait_chg(ir_tx_pin, t);
        rf_acc(1'b1, `IRCT_RF_TX_GATE, 4'h0);
        wait_chg(ir_tx_pin, t);
        chk(16'(t), 16'h0004, "high pulse kept after gate off");
        repeat (20) @(negedge mclk);
        chk({ir_tx_pin, tx_indicator_pin}, 16'h0001, "gate off");
    endtask

    task automatic t_sync();
        int t;
        int n;
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'h7); // alternate clock, stopped
        db_acc(1'b1, `IRCT_PA_T8, 8'h14);
        rf_acc(1'b1, `IRCT_RF_T8_SYNC, 4'h9); // paired mode, external source
        ext_run = 1'b1;
        rf_acc(1'b1, `IRCT_RF_T8_SYNC, 4'hD);
        wait_chg(t10_run, t);
        chk({t10_run, 7'h00, 8'(t <= 30)}, 16'h8001, "paired start");
        n = 0;
        repeat (60) @(negedge mclk) n += t10_count_tick;
        chk(16'(n), 16'h0000, "no count with envelope low");
        env_hi = 1'b1;
        wait_chg(t10_count_tick, t);
        chk(t10_count_tick, 16'h0001, "count with envelope high");
        wait_chg(t8_match_irq_flag, t);
        repeat (40) @(negedge mclk);
        ext_run = 1'b0;
        db_acc(1'b0, `IRCT_PA_T8, 8'h00);
        chk(rd8, 16'h0014, "count held at limit");
        rf_acc(1'b0, `IRCT_RF_T8_CTRL, 4'h0);
        chk(rd8, 16'h0003, "t8 enable cleared");
        rf_acc(1'b0, `IRCT_RF_T8_SYNC, 4'h0);
        chk({rd8, 7'h00, t10_run}, 16'h0900, "t10 stopped");
    endtask

    task automatic t_cmp();
        rf_acc(1'b1, `IRCT_RF_T8_SYNC, 4'h1); // unpaired, external source
        rf_acc(1'b1, `IRCT_RF_T8_CTRL, 4'hF);
        cmp_run = 1'b1;
        repeat (80) @(negedge mclk);
        cmp_run = 1'b0;
        repeat (10) @(negedge mclk);
        db_acc(1'b0, `IRCT_PA_T8, 8'h00);
        chk(rd8, 16'h000A, "count from comparator pulses");
    endtask

    initial
    begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_clksel();
        t_hold();
        t_carrier();
        t_sync();
        t_cmp();
        summarize();
    end
endmodule
